// ==== rtl/cdbs_bridge.sv ====
// Processor clock generator, stretcher and DMA bus bridge control
`include "cdbs_defs.svh"

module cdbs_bridge #(
    parameter int unsigned TICK_DIV = `CDBS_TICK_DIV
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   power_valid,
    input  wire cdbs_pkg::cdbs_cpu_bus_t cpu_bus,
    output logic [7:0]                  cpu_rdata,
    output logic                        cpu_e,
    output logic                        cpu_q,
    output logic                        cpu_bus_request_n,
    input  wire logic                   cpu_grant,
    input  wire logic                   local_xfer_active,
    input  wire logic                   remote_xfer_active,
    input  wire logic                   remote_buf1_sel,
    output logic                        bridge_xcvr_enable_n,
    output logic                        upper_xcvr_enable_n,
    output logic                        buf0_cs_n,
    output logic                        buf1_cs_n,
    output logic                        iface_cs_n,
    output logic                        dma_read_strobe_n,
    output logic                        dma_write_strobe_n,
    output cdbs_pkg::cdbs_ctrl_t        drive_ctrl,
    input  wire cdbs_pkg::cdbs_status_t drive_status
);

    // ----------------------------------------------------------------
    // Reset and state machine tick
    // ----------------------------------------------------------------
    wire  logic        rst_all = rst || !power_valid;
    logic [7:0]        div_q;
    logic              tick_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
        begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q  <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
            tick_q <= (div_q == 8'(TICK_DIV - 1));
        end
    end

    // ----------------------------------------------------------------
    // Chip select decoder
    // ----------------------------------------------------------------
    wire logic [2:0] buf_page = cpu_bus.addr[15:`CDBS_BUF_LSB];
    wire logic [4:0] io_page  = cpu_bus.addr[15:`CDBS_IO_LSB];
    wire logic hit_buf0 = cpu_bus.vma && (buf_page == `CDBS_BUF0_PAGE);
    wire logic hit_buf1 = cpu_bus.vma && (buf_page == `CDBS_BUF1_PAGE);
    wire logic hit_ddc  = cpu_bus.vma && (io_page == `CDBS_DDC_PAGE);
    wire logic hit_ifc  = cpu_bus.vma && (io_page == `CDBS_IFC_PAGE);
    wire logic hit_ctrl = cpu_bus.vma && (io_page == `CDBS_CTRL_PAGE);
    wire logic hit_stat = cpu_bus.vma && (io_page == `CDBS_STAT_PAGE);
    wire logic dma_sel  = hit_buf0 || hit_buf1 || hit_ddc || hit_ifc;

    // ----------------------------------------------------------------
    // Clock state machine
    // ----------------------------------------------------------------
    cdbs_pkg::cdbs_state_t state_q;
    cdbs_pkg::cdbs_state_t state_d;
    logic                  stretch_done;

    always_comb
    begin
        state_d = state_q;
        if (tick_q)
        begin
            unique case (state_q)
                cdbs_pkg::CDBS_P0:  state_d = cdbs_pkg::CDBS_P1;
                cdbs_pkg::CDBS_P1:  state_d = cdbs_pkg::CDBS_P2;
                cdbs_pkg::CDBS_P2:  state_d = dma_sel ? cdbs_pkg::CDBS_STR : cdbs_pkg::CDBS_P3;
                cdbs_pkg::CDBS_P3:  state_d = cdbs_pkg::CDBS_P0;
                cdbs_pkg::CDBS_STR: state_d = stretch_done ? cdbs_pkg::CDBS_P0 : cdbs_pkg::CDBS_STR;
                default:            state_d = cdbs_pkg::CDBS_P0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            state_q <= cdbs_pkg::CDBS_P0;
        else
            state_q <= state_d;
    end

    wire logic in_str = (state_q == cdbs_pkg::CDBS_STR);
    assign cpu_e = (state_q == cdbs_pkg::CDBS_P2) || (state_q == cdbs_pkg::CDBS_P3) || in_str;
    assign cpu_q = (state_q == cdbs_pkg::CDBS_P1) || (state_q == cdbs_pkg::CDBS_P2);
    assign cpu_bus_request_n = !in_str;

    // ----------------------------------------------------------------
    // Grant sequencer
    // ----------------------------------------------------------------
    logic addr_select_phase;
    logic strobe_phase;

    cdbs_tick_delay #(.TICKS(`CDBS_ASEL_TICKS)) u_asel (
        .sys_clk (sys_clk),
        .rst     (rst_all),
        .tick    (tick_q),
        .clr     (!cpu_grant),
        .start   (cpu_grant),
        .done    (addr_select_phase)
    );

    cdbs_tick_delay #(.TICKS(`CDBS_STROBE_TICKS)) u_strobe (
        .sys_clk (sys_clk),
        .rst     (rst_all),
        .tick    (tick_q),
        .clr     (!cpu_grant),
        .start   (addr_select_phase),
        .done    (strobe_phase)
    );

    cdbs_tick_delay #(.TICKS(`CDBS_STOP_TICKS)) u_stop (
        .sys_clk (sys_clk),
        .rst     (rst_all),
        .tick    (tick_q),
        .clr     (!cpu_grant),
        .start   (strobe_phase),
        .done    (stretch_done)
    );

    // ----------------------------------------------------------------
    // Transceivers, chip selects and strobes
    // ----------------------------------------------------------------
    wire logic cpu_path = addr_select_phase && in_str && !local_xfer_active;
    wire logic upper_cpu    = cpu_path && hit_buf1;
    wire logic upper_remote = remote_xfer_active && remote_buf1_sel;

    assign bridge_xcvr_enable_n = !cpu_path;
    assign upper_xcvr_enable_n  = !(local_xfer_active || upper_remote || upper_cpu);
    assign buf0_cs_n            = !(cpu_path && hit_buf0);
    assign buf1_cs_n            = !(cpu_path && hit_buf1);
    assign iface_cs_n           = !(cpu_path && hit_ifc);
    assign dma_read_strobe_n    = !(cpu_path && strobe_phase && cpu_bus.rw);
    assign dma_write_strobe_n   = !(cpu_path && strobe_phase && !cpu_bus.rw);

    // ----------------------------------------------------------------
    // Control bit latch and status port
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    wire  logic ctrl_wr = tick_q && (state_q == cdbs_pkg::CDBS_P3) && hit_ctrl && !cpu_bus.rw;

    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            ctrl_q <= `CDBS_CTRL_RST;
        else if (ctrl_wr)
            ctrl_q <= cpu_bus.wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            rdata_q <= `CDBS_RDATA_RST;
        else if (hit_stat && cpu_bus.rw)
            rdata_q <= {1'b0, drive_status};
        else
            rdata_q <= `CDBS_RDATA_RST;
    end

    assign drive_ctrl = cdbs_pkg::cdbs_ctrl_t'(ctrl_q);
    assign cpu_rdata  = rdata_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [3:0] asel_ticks_q;
    logic [3:0] strobe_ticks_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst_all || !addr_select_phase)
            asel_ticks_q <= 4'h0;
        else if (tick_q && asel_ticks_q != 4'hF)
            asel_ticks_q <= asel_ticks_q + 4'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst_all || !strobe_phase)
            strobe_ticks_q <= 4'h0;
        else if (tick_q && strobe_ticks_q != 4'hF)
            strobe_ticks_q <= strobe_ticks_q + 4'h1;
    end

    bridge_only_grant_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !bridge_xcvr_enable_n |-> cpu_grant && dma_sel && !local_xfer_active)
        else $error("bridge enabled without grant or target");

    local_upper_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        local_xfer_active |-> !upper_xcvr_enable_n && bridge_xcvr_enable_n)
        else $error("local transfer without both halves");

    remote_upper_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        remote_xfer_active && !local_xfer_active && !upper_cpu |-> upper_xcvr_enable_n == !remote_buf1_sel)
        else $error("upper transceiver wrong for remote transfer");

    stretch_hold_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        in_str |-> cpu_e && !cpu_q && !cpu_bus_request_n)
        else $error("stretch clocks wrong");

    stretch_exit_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        in_str && tick_q && stretch_done |=> !cpu_e && cpu_bus_request_n)
        else $error("stretch exit wrong");

    divide_four_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        state_q == cdbs_pkg::CDBS_P0 && tick_q |=> cpu_q && !cpu_e ##1 cpu_q [*3])
        else $error("divide by four broken");

    asel_after_grant_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        tick_q && cpu_grant && !addr_select_phase && $past(cpu_grant) |=> addr_select_phase)
        else $error("address select late");

    strobe_delay_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        $rose(strobe_phase) |-> asel_ticks_q == 4'h2)
        else $error("strobe phase not two ticks after select");

    stop_delay_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        $rose(stretch_done) |-> strobe_ticks_q == 4'h4)
        else $error("stretch done not four ticks after strobe");

    grant_clear_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !cpu_grant |=> !addr_select_phase && !strobe_phase && !stretch_done)
        else $error("sequencer not cleared on grant drop");

    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        ctrl_wr |=> drive_ctrl == $past(cpu_bus.wdata))
        else $error("control latch missed write");

    reset_idle_a: assert property (@(posedge sys_clk)
        rst_all |=> state_q == cdbs_pkg::CDBS_P0 && ctrl_q == `CDBS_CTRL_RST && bridge_xcvr_enable_n)
        else $error("reset did not idle");

    // ----------------------------------------------------------------
    // Select, strobe, transceiver, stretch, grant, control and status checks
    // ----------------------------------------------------------------
    ddc_no_select_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        hit_ddc |-> buf0_cs_n && buf1_cs_n && iface_cs_n)
        else $error("chip select driven for controller access");

    select_needs_bridge_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !(buf0_cs_n && buf1_cs_n && iface_cs_n) |-> !bridge_xcvr_enable_n && addr_select_phase)
        else $error("chip select without bridge enable");

    strobe_read_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !dma_read_strobe_n |-> strobe_phase && cpu_bus.rw && !bridge_xcvr_enable_n)
        else $error("read strobe out of phase");

    strobe_write_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !dma_write_strobe_n |-> strobe_phase && !cpu_bus.rw && !bridge_xcvr_enable_n)
        else $error("write strobe out of phase");

    upper_cpu_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !bridge_xcvr_enable_n && !remote_xfer_active |-> upper_xcvr_enable_n == !hit_buf1)
        else $error("upper transceiver wrong for processor access");

    stretch_entry_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        state_q == cdbs_pkg::CDBS_P2 && tick_q && dma_sel |=> in_str && !cpu_bus_request_n)
        else $error("stretch not started for DMA target");

    no_stretch_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        state_q == cdbs_pkg::CDBS_P2 && tick_q && !dma_sel |=> state_q == cdbs_pkg::CDBS_P3 && cpu_e && !cpu_q)
        else $error("clock stretched without DMA target");

    asel_needs_grant_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        addr_select_phase |-> $past(cpu_grant))
        else $error("address select without grant");

    ctrl_hold_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !ctrl_wr |=> $stable(drive_ctrl))
        else $error("control bits changed without write");

    stat_read_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        hit_stat && cpu_bus.rw |=> cpu_rdata == {1'b0, $past(drive_status)})
        else $error("status port read wrong");

    stat_idle_a: assert property (@(posedge sys_clk) disable iff (rst_all)
        !(hit_stat && cpu_bus.rw) |=> cpu_rdata == 8'h00)
        else $error("status data outside a read");

endmodule

// ==== rtl/cdbs_defs.svh ====
// Constants of the processor to DMA bus access stretcher
`ifndef CDBS_DEFS_SVH
`define CDBS_DEFS_SVH

// ----------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------
`define CDBS_SYS_CLK_HZ     250000000
`define CDBS_SM_CLK_HZ      12000000
`define CDBS_TICK_DIV       (`CDBS_SYS_CLK_HZ / `CDBS_SM_CLK_HZ)
`define CDBS_PHASE_DIV      4

// ----------------------------------------------------------------
// Sequencer delays in state machine ticks
// ----------------------------------------------------------------
`define CDBS_ASEL_TICKS     1
`define CDBS_STROBE_TICKS   2
`define CDBS_STOP_TICKS     4

// ----------------------------------------------------------------
// Address decode, processor side
// ----------------------------------------------------------------
`define CDBS_BUF_LSB        13
`define CDBS_BUF0_PAGE      3'h2
`define CDBS_BUF1_PAGE      3'h3
`define CDBS_IO_LSB         11
`define CDBS_DDC_PAGE       5'h02
`define CDBS_IFC_PAGE       5'h03
`define CDBS_CTRL_PAGE      5'h04
`define CDBS_STAT_PAGE      5'h05

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CDBS_CTRL_RST       8'h00
`define CDBS_RDATA_RST      8'h00

`endif

// ==== rtl/cdbs_pkg.sv ====
// Types of the processor to DMA bus access stretcher
package cdbs_pkg;

    // ----------------------------------------------------------------
    // Clock state machine, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        CDBS_P0  = 5'b00001,
        CDBS_P1  = 5'b00010,
        CDBS_P2  = 5'b00100,
        CDBS_P3  = 5'b01000,
        CDBS_STR = 5'b10000
    } cdbs_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        rw;
        logic        vma;
        logic [7:0]  wdata;
    } cdbs_cpu_bus_t;

    typedef struct packed {
        logic       transfer_request;
        logic       command_data;
        logic       rg_delay_load;
        logic       eeprom_data;
        logic       drive_sel;
        logic [2:0] head_sel;
    } cdbs_ctrl_t;

    typedef struct packed {
        logic command_complete;
        logic config_status;
        logic attention;
        logic transfer_ack;
        logic ready;
        logic sector;
        logic index;
    } cdbs_status_t;

endpackage

// ==== rtl/cdbs_tick_delay.sv ====
// Level that rises a set number of ticks after its input rises
module cdbs_tick_delay #(
    parameter int unsigned TICKS = 1
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic clr,
    input  wire logic start,
    output logic      done
);

    logic [3:0] cnt_q;
    logic       done_q;
    wire  logic last = (cnt_q == 4'(TICKS - 1));

    always_ff @(posedge sys_clk)
    begin
        if (rst || clr || !start)
        begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
        end
        else if (tick && !done_q)
        begin
            cnt_q  <= last ? cnt_q : cnt_q + 4'h1;
            done_q <= last;
        end
    end

    assign done = done_q;

endmodule

// ==== sim/cdbs_arb_model.sv ====
// Behavioural DMA bus arbiter that grants the processor after a set delay
module cdbs_arb_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       cpu_bus_request_n,
    input  wire logic [7:0] grant_delay,
    output logic            cpu_grant
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] wait_q;

    // ----------------------------------------------------------------
    // Grant on request only, hold until release
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst || cpu_bus_request_n)
        begin
            wait_q    <= 8'h00;
            cpu_grant <= 1'b0;
        end
        else if (wait_q >= grant_delay)
            cpu_grant <= 1'b1;
        else
            wait_q <= wait_q + 8'h01;
    end
endmodule

// ==== sim/cdbs_bridge_tb.sv ====
// Self-checking bench of the processor to DMA bus access stretcher
module cdbs_bridge_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TDIV = 4;
    typedef struct {
        logic [15:0] addr;
        logic        rw;
        logic [2:0]  cs;
        logic        up;
        logic [7:0]  gdly;
    } cdbs_row_t;

    logic                   sys_clk, rst, power_valid, cpu_grant, cpu_e, cpu_q;
    logic                   cpu_bus_request_n, local_xfer_active, remote_xfer_active, remote_buf1_sel;
    logic                   bridge_xcvr_enable_n, upper_xcvr_enable_n, buf0_cs_n, buf1_cs_n, iface_cs_n;
    logic                   dma_read_strobe_n, dma_write_strobe_n;
    logic [7:0]             cpu_rdata, gdly;
    cdbs_pkg::cdbs_cpu_bus_t cpu_bus;
    cdbs_pkg::cdbs_ctrl_t    drive_ctrl;
    cdbs_pkg::cdbs_status_t  drive_status;
    int                     fails, samples_checked, n;
    cdbs_row_t              rows [6] = '{
        '{16'h4010, 1'b1, 3'b100, 1'b0, 8'h00},
        '{16'h7FFF, 1'b0, 3'b010, 1'b1, 8'h1E},
        '{16'h1800, 1'b1, 3'b001, 1'b0, 8'h00},
        '{16'h1000, 1'b0, 3'b000, 1'b0, 8'h05},
        '{16'h5FFF, 1'b0, 3'b100, 1'b0, 8'h00},
        '{16'h6000, 1'b1, 3'b010, 1'b1, 8'h2A}};

    cdbs_bridge #(.TICK_DIV(TDIV)) dut (.sys_clk(sys_clk), .rst(rst), .power_valid(power_valid),
        .cpu_bus(cpu_bus), .cpu_rdata(cpu_rdata), .cpu_e(cpu_e), .cpu_q(cpu_q),
        .cpu_bus_request_n(cpu_bus_request_n), .cpu_grant(cpu_grant), .local_xfer_active(local_xfer_active),
        .remote_xfer_active(remote_xfer_active), .remote_buf1_sel(remote_buf1_sel),
        .bridge_xcvr_enable_n(bridge_xcvr_enable_n), .upper_xcvr_enable_n(upper_xcvr_enable_n),
        .buf0_cs_n(buf0_cs_n), .buf1_cs_n(buf1_cs_n), .iface_cs_n(iface_cs_n),
        .dma_read_strobe_n(dma_read_strobe_n), .dma_write_strobe_n(dma_write_strobe_n),
        .drive_ctrl(drive_ctrl), .drive_status(drive_status));

    cdbs_arb_model arb (.sys_clk(sys_clk), .rst(rst), .cpu_bus_request_n(cpu_bus_request_n),
        .grant_delay(gdly), .cpu_grant(cpu_grant));

    always #2 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Compare and report
    // ----------------------------------------------------------------
    task automatic report(input bit ok, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        report(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        report(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic check_count(input int got, input int exp);
        report(got == exp, 32'(got), 32'(exp));
    endtask
    task automatic check_limit(input int got, input int lim);
        if (got >= lim)
        begin
            fails++;
            end_sim();
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // One processor access to the DMA bus, watched every cycle
    // ----------------------------------------------------------------
    task automatic run_access(input cdbs_row_t r);
        int   cyc, tg, tb, ts, te;
        logic s0, s1, si, srd, swr, sup, bad_eq, bad_br, started;
        cyc = 0; tg = -1; tb = -1; ts = -1; te = -1;
        {s0, s1, si, srd, swr, sup, bad_eq, bad_br, started} = 9'h000;
        gdly = r.gdly;
        cpu_bus = '{r.addr, r.rw, 1'b1, 8'h3C};
        while (te < 0 && cyc < 300)
        begin
            @(negedge sys_clk);
            cyc++;
            if (cpu_bus_request_n === 1'b0)
                started = 1'b1;
            if (started && cpu_bus_request_n === 1'b1)
                te = cyc;
            else if (started && (cpu_e !== 1'b1 || cpu_q !== 1'b0))
                bad_eq = 1'b1;
            if (cpu_grant === 1'b1 && tg < 0)
                tg = cyc;
            if (bridge_xcvr_enable_n === 1'b0 && tb < 0)
                tb = cyc;
            if (bridge_xcvr_enable_n === 1'b0 && cpu_grant !== 1'b1)
                bad_br = 1'b1;
            if ((dma_read_strobe_n & dma_write_strobe_n) === 1'b0 && ts < 0)
                ts = cyc;
            s0 |= (buf0_cs_n === 1'b0);
            s1 |= (buf1_cs_n === 1'b0);
            si |= (iface_cs_n === 1'b0);
            srd |= (dma_read_strobe_n === 1'b0);
            swr |= (dma_write_strobe_n === 1'b0);
            sup |= (upper_xcvr_enable_n === 1'b0);
        end
        if (te < 0)
        begin
            fails++;
            end_sim();
        end
        check_bit(cpu_e, 1'b0);
        check_bit({s0, s1, si} === r.cs, 1'b1);
        check_bit(sup, r.up);
        check_bit(srd, r.rw);
        check_bit(swr, !r.rw);
        check_bit(bad_eq, 1'b0);
        check_bit(bad_br, 1'b0);
        check_bit((tb - tg >= 1) && (tb - tg <= TDIV), 1'b1);
        check_count(ts - tb, 2 * TDIV);
        check_count(te - ts, 5 * TDIV);
    endtask

    initial
    begin
        sys_clk = 1'b0; rst = 1'b1; power_valid = 1'b1; gdly = 8'h00;
        local_xfer_active = 1'b0; remote_xfer_active = 1'b0; remote_buf1_sel = 1'b0;
        cpu_bus = '{16'h4000, 1'b1, 1'b0, 8'h00};
        drive_status = 7'h00;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        // Idle division, DMA address without valid flag
        n = 0;
        while (cpu_e !== 1'b0 && n < 40) begin @(negedge sys_clk); n++; end
        while (cpu_e !== 1'b1 && n < 40) begin @(negedge sys_clk); n++; end
        check_limit(n, 40);
        check_bit(cpu_q, 1'b1);
        n = 0;
        while (cpu_e === 1'b1 && n < 40) begin @(negedge sys_clk); n++; end
        check_limit(n, 40);
        check_count(n, 2 * TDIV);
        check_bit(cpu_q, 1'b0);
        n = 0;
        while (cpu_e === 1'b0 && n < 40) begin @(negedge sys_clk); n++; end
        check_limit(n, 40);
        check_count(n, 2 * TDIV);
        check_bit(cpu_bus_request_n, 1'b1);
        // Table of accesses, back to back
        foreach (rows[i])
            run_access(rows[i]);
        cpu_bus.vma = 1'b0;
        // Control latch and status port
        foreach (rows[i])
        begin
            cpu_bus = '{16'h2000 + 16'(i), 1'b0, 1'b1, 8'hA5 ^ 8'(i * 8'h3F)};
            repeat (4 * TDIV + 1) @(negedge sys_clk);
            check_byte(drive_ctrl, 8'hA5 ^ 8'(i * 8'h3F));
            drive_status = 7'h55 ^ 7'(i * 7'h13);
            cpu_bus = '{16'h2800 + 16'(i), 1'b1, 1'b1, 8'h00};
            repeat (2) @(negedge sys_clk);
            check_byte(cpu_rdata, {1'b0, 7'h55 ^ 7'(i * 7'h13)});
        end
        cpu_bus.vma = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_byte(cpu_rdata, 8'h00);
        // Transceiver steering for local and remote traffic
        local_xfer_active = 1'b1;
        @(negedge sys_clk);
        check_bit(upper_xcvr_enable_n, 1'b0);
        check_bit(bridge_xcvr_enable_n, 1'b1);
        local_xfer_active = 1'b0;
        remote_xfer_active = 1'b1;
        remote_buf1_sel = 1'b1;
        @(negedge sys_clk);
        check_bit(upper_xcvr_enable_n, 1'b0);
        remote_buf1_sel = 1'b0;
        @(negedge sys_clk);
        check_bit(upper_xcvr_enable_n, 1'b1);
        remote_xfer_active = 1'b0;
        // Supply drop in mid stretch, then recovery
        cpu_bus = '{16'h4000, 1'b0, 1'b1, 8'h00};
        n = 0;
        while (bridge_xcvr_enable_n !== 1'b0 && n < 100) begin @(negedge sys_clk); n++; end
        check_limit(n, 100);
        check_bit(bridge_xcvr_enable_n, 1'b0);
        // Local transfer in mid stretch
        local_xfer_active = 1'b1;
        @(negedge sys_clk);
        check_bit(bridge_xcvr_enable_n, 1'b1);
        check_bit(buf0_cs_n, 1'b1);
        check_bit(upper_xcvr_enable_n, 1'b0);
        local_xfer_active = 1'b0;
        @(negedge sys_clk);
        check_bit(bridge_xcvr_enable_n, 1'b0);
        check_bit(buf0_cs_n, 1'b0);
        power_valid = 1'b0;
        cpu_bus.vma = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_bit({cpu_e, cpu_q, cpu_bus_request_n} === 3'b001, 1'b1);
        check_bit({bridge_xcvr_enable_n, buf0_cs_n, buf1_cs_n, iface_cs_n,
                   dma_read_strobe_n, dma_write_strobe_n} === 6'h3F, 1'b1);
        check_byte(drive_ctrl, 8'h00);
        power_valid = 1'b1;
        run_access(rows[1]);
        cpu_bus.vma = 1'b0;
        end_sim();
    end
endmodule
